// ---- ictl_top.sv ----
// Clock control: tuning, postscaler, multiplier lock and glitch-free source switch
`include "ictl_cfg.svh"

// Contract
// - A tuning write starts moving the fast oscillator at once, with no done flag.
// - Tuning field is two's complement: 011111 max, 000000 centre, 100000 min.
// - Tuning affects only the fast oscillator, never the low-frequency RC.
// - Bit 7 picks 31 kHz: fast oscillator divided by 256, or the RC.
// - That choice applies only while the postscaler field is 000.
// - Bit 6 enables the 4x multiplier, giving up to 32 MHz.
// - Multiplier only with oscillator config 011 or 010 and clock select 00.
// - Multiplier only with postscaler field 111 or 110.
// - Keep the old clock during up to 2 ms lock, then switch automatically.
// - Writing clock select changes source after a short pause, no more software.
// - Every reset clears the clock select field.
// - Postscaler changes alter the internal clock frequency immediately.
// - Reset sets the postscaler to 4 MHz.
// - Watchdog and fail-safe monitor always run from the low-frequency RC.
// - Start-up flag marks primary, Timer1 flag marks Timer1; never both.
// - Idle-select bit picks idle or full sleep on the sleep instruction.
// - Timer1 selection is ignored unless crystal driver or digital input enabled.
// - Switch pauses two old-source ticks plus three to four new-source ticks.
// - Fast internal oscillator nominally runs at 8.0 MHz.
// - Clock select: 11 internal, 10 reserved, 01 Timer1, 00 primary.
// - Postscaler: 111 8 MHz down by halves to 001 125 kHz; 000 31 kHz.
module ictl_top #(
    parameter int LOCK_CYCLES = `ICTL_LOCK_CYCLES
) (
    // Clock and reset
    input  wire logic                 clk_i,
    input  wire logic                 rstn_i,
    // AHB-Lite slave
    input  wire logic                 hsel_i,
    input  wire logic [31:0]          haddr_i,
    input  wire logic [1:0]           htrans_i,
    input  wire logic                 hwrite_i,
    input  wire logic [2:0]           hsize_i,
    input  wire logic [31:0]          hwdata_i,
    input  wire logic                 hready_i,
    output logic      [31:0]          hrdata_o,
    output logic                      hreadyout_o,
    output logic                      hresp_o,
    // Source ticks and configuration
    input  wire ictl_pkg::ictl_ticks_t ticks_i,
    input  wire logic [2:0]           oscillator_config_field_i,
    input  wire logic                 timer1_crystal_driver_enable_i,
    input  wire logic                 timer1_digital_input_config_i,
    input  wire logic                 ost_done_i,
    input  wire logic                 sleep_exec_i,
    // Clock outputs and status
    output logic                      sys_clk_tick_o,
    output logic                      wdt_clk_tick_o,
    output logic [5:0]                fast_osc_trim_o,
    output logic                      mult_run_o,
    output logic                      mult_ready_o,
    output logic                      switching_o,
    output logic                      timer1_clock_running_flag_o,
    output logic                      enter_idle_o,
    output logic                      enter_sleep_o
);
    import ictl_pkg::*;

    localparam int LCW = $clog2(LOCK_CYCLES + 1);

    ictl_tune_t     osc_tune;
    ictl_ctrl_t     osc_ctrl;
    logic           dphase;
    logic           dwrite;
    logic [11:0]    didx;
    logic           wr_tune;
    logic           wr_ctrl;
    logic [7:0]     wdata;
    logic           t1_allowed;
    logic           startup_flag;
    logic [7:0]     div_cnt;
    logic           postscaled_tick;
    logic           primary_tick;
    logic           mult_allowed;
    logic [LCW-1:0] lock_cnt;
    logic           mult_locked;
    ictl_src_t      cur_src;
    ictl_src_t      tgt_src;
    ictl_src_t      next_src;
    ictl_sw_t       sw_state;
    logic [1:0]     tick_cnt;

    // Tick of a given source; lets the switch count old and new clocks alike
    function automatic logic src_tick(input ictl_src_t s, input logic prim,
                                      input logic intc, input ictl_ticks_t t);
        case (s)
            SRC_PRIM: src_tick = prim;
            SRC_T1:   src_tick = t.timer1;
            SRC_INTC: src_tick = intc;
            SRC_MULT: src_tick = t.multiplied;
            default:  src_tick = 1'b0;
        endcase
    endfunction

    // Zero wait states; every transfer answers OKAY
    assign hreadyout_o = 1'b1;
    assign hresp_o     = 1'b0;

    // Address phase capture
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            dphase <= 1'b0;
            dwrite <= 1'b0;
            didx   <= 12'h000;
        end else if (hready_i) begin
            dphase <= hsel_i && htrans_i[1];
            dwrite <= hwrite_i;
            didx   <= haddr_i[`ICTL_IDX_MSB:`ICTL_IDX_LSB];
        end
    end

    assign wdata   = hwdata_i[7:0];
    assign wr_tune = dphase && dwrite && (didx == `ICTL_IDX_TUNE);
    assign wr_ctrl = dphase && dwrite && (didx == `ICTL_IDX_CTRL);

    // Read data is registered at the address phase so it is stable in the data phase;
    // unmapped indices read as zero
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            hrdata_o <= 32'h0000_0000;
        end else if (hready_i && hsel_i && htrans_i[1] && !hwrite_i) begin
            case (haddr_i[`ICTL_IDX_MSB:`ICTL_IDX_LSB])
                `ICTL_IDX_TUNE: hrdata_o <= {24'h00_0000, osc_tune};
                `ICTL_IDX_CTRL: hrdata_o <= {24'h00_0000, osc_ctrl.idle_select,
                                             osc_ctrl.postscaler_freq_select, startup_flag,
                                             `ICTL_CTRL_UNUSED_VAL,
                                             osc_ctrl.system_clock_select};
                default:        hrdata_o <= 32'h0000_0000;
            endcase
        end
    end

    // Tuning register; the trim follows the code with no completion handshake
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            osc_tune <= `ICTL_TUNE_RESET;
        end else if (wr_tune) begin
            osc_tune <= wdata;
        end
    end

    // Signed code goes straight to the fast oscillator trim only; the RC has no trim
    assign fast_osc_trim_o = osc_tune.tuning_field;

    // Timer1 may be picked only when its clock can actually run
    assign t1_allowed = timer1_crystal_driver_enable_i || timer1_digital_input_config_i;

    // Control register; reserved and refused selects keep the old value
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            osc_ctrl <= `ICTL_CTRL_RESET;
        end else if (wr_ctrl) begin
            osc_ctrl.idle_select            <= wdata[7];
            osc_ctrl.postscaler_freq_select <= wdata[6:4];
            if (wdata[1:0] == `ICTL_SCS_TIMER1) begin
                if (t1_allowed) begin
                    osc_ctrl.system_clock_select <= wdata[1:0];
                end
            end else if (wdata[1:0] != `ICTL_SCS_RESERVED) begin
                osc_ctrl.system_clock_select <= wdata[1:0];
            end
        end
    end

    // Postscaler divider runs free on the fast oscillator ticks
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            div_cnt <= 8'h00;
        end else if (ticks_i.fast_osc) begin
            div_cnt <= div_cnt + 8'h01;
        end
    end

    // Frequency choice is combinational so a new setting takes effect at once
    always_comb begin
        case (osc_ctrl.postscaler_freq_select)
            3'h7:    postscaled_tick = ticks_i.fast_osc;
            3'h6:    postscaled_tick = ticks_i.fast_osc && (div_cnt[0] == 1'b1);
            3'h5:    postscaled_tick = ticks_i.fast_osc && (div_cnt[1:0] == 2'h3);
            3'h4:    postscaled_tick = ticks_i.fast_osc && (div_cnt[2:0] == 3'h7);
            3'h3:    postscaled_tick = ticks_i.fast_osc && (div_cnt[3:0] == 4'hf);
            3'h2:    postscaled_tick = ticks_i.fast_osc && (div_cnt[4:0] == 5'h1f);
            3'h1:    postscaled_tick = ticks_i.fast_osc && (div_cnt[5:0] == 6'h3f);
            default: postscaled_tick = osc_tune.low_freq_source_select
                                     ? (ticks_i.fast_osc && (div_cnt == 8'hff))
                                     : ticks_i.lf_rc;
        endcase
    end

    // Internal oscillator modes take the primary clock from the postscaler
    always_comb begin
        case (oscillator_config_field_i)
            `ICTL_FOSC_INTERNAL_MULTIPLIED_MODES_A, `ICTL_FOSC_INTERNAL_MULTIPLIED_MODES_B,
            `ICTL_FOSC_INTPS_A, `ICTL_FOSC_INTPS_B: primary_tick = postscaled_tick;
            default:                                primary_tick = ticks_i.primary;
        endcase
    end

    // Multiplier runs only in a legal mode, on the primary source, at 8 or 4 MHz
    assign mult_allowed = osc_tune.multiplier_enable
        && ((oscillator_config_field_i == `ICTL_FOSC_INTERNAL_MULTIPLIED_MODES_A)
            || (oscillator_config_field_i == `ICTL_FOSC_INTERNAL_MULTIPLIED_MODES_B))
        && (osc_ctrl.system_clock_select == `ICTL_SCS_PRIMARY)
        && ((osc_ctrl.postscaler_freq_select == `ICTL_IRCF_8MHZ)
            || (osc_ctrl.postscaler_freq_select == `ICTL_IRCF_4MHZ));
    assign mult_run_o = mult_allowed;

    // Lock wait timed on the system clock, restarted whenever the multiplier drops
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            lock_cnt    <= '0;
            mult_locked <= 1'b0;
        end else if (!mult_allowed) begin
            lock_cnt    <= '0;
            mult_locked <= 1'b0;
        end else if (!mult_locked) begin
            if (lock_cnt == LCW'(LOCK_CYCLES - 1)) begin
                mult_locked <= 1'b1;
            end
            lock_cnt <= lock_cnt + 1'b1;
        end
    end
    assign mult_ready_o = mult_locked && mult_allowed; // Falls with the enable, not a cycle late

    // Wanted source; the lock ready moves the primary path onto the multiplier
    always_comb begin
        case (osc_ctrl.system_clock_select)
            `ICTL_SCS_TIMER1:   next_src = SRC_T1;
            `ICTL_SCS_INTERNAL: next_src = SRC_INTC;
            default:            next_src = mult_ready_o ? SRC_MULT : SRC_PRIM;
        endcase
    end

    // Glitch-free switch: gate, wait old ticks, then new ticks, then hand over.
    // A source that never ticks stalls the switch, hence the advice to start Timer1 first.
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            sw_state <= SW_RUN;
            cur_src  <= SRC_PRIM;
            tgt_src  <= SRC_PRIM;
            tick_cnt <= 2'd0;
        end else begin
            case (sw_state)
                SW_RUN: begin
                    if (next_src != cur_src) begin
                        tgt_src  <= next_src;
                        tick_cnt <= 2'd0;
                        sw_state <= SW_OLD;
                    end
                end
                SW_OLD: begin
                    if (src_tick(cur_src, primary_tick, postscaled_tick, ticks_i)) begin
                        if (tick_cnt == `ICTL_OLD_TICKS - 2'd1) begin
                            tick_cnt <= 2'd0;
                            sw_state <= SW_NEW;
                        end else begin
                            tick_cnt <= tick_cnt + 2'd1;
                        end
                    end
                end
                SW_NEW: begin
                    if (src_tick(tgt_src, primary_tick, postscaled_tick, ticks_i)) begin
                        if (tick_cnt == `ICTL_NEW_TICKS - 2'd1) begin
                            tick_cnt <= 2'd0;
                            cur_src  <= tgt_src;
                            sw_state <= SW_RUN;
                        end else begin
                            tick_cnt <= tick_cnt + 2'd1;
                        end
                    end
                end
                default: sw_state <= SW_RUN;
            endcase
        end
    end
    assign switching_o = (sw_state != SW_RUN);

    // Device clock tick, held low during a switch
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            sys_clk_tick_o <= 1'b0;
        end else begin
            sys_clk_tick_o <= (sw_state == SW_RUN)
                && src_tick(cur_src, primary_tick, postscaled_tick, ticks_i);
        end
    end

    // Watchdog and monitor never follow the low-frequency source choice
    assign wdt_clk_tick_o = ticks_i.lf_rc;

    // Source flags; exclusive because the current source is one value
    assign startup_flag = (sw_state == SW_RUN) && ost_done_i
        && ((cur_src == SRC_PRIM) || (cur_src == SRC_MULT));
    assign timer1_clock_running_flag_o = (sw_state == SW_RUN) && (cur_src == SRC_T1);

    // Sleep instruction goes to idle or sleep
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            enter_idle_o  <= 1'b0;
            enter_sleep_o <= 1'b0;
        end else begin
            enter_idle_o  <= sleep_exec_i && osc_ctrl.idle_select;
            enter_sleep_o <= sleep_exec_i && !osc_ctrl.idle_select;
        end
    end

    // Checks
    sequence s_old_done;
        (sw_state == SW_OLD) && (tick_cnt == 2'd1)
            && src_tick(cur_src, primary_tick, postscaled_tick, ticks_i);
    endsequence

    sequence s_new_entered;
        (sw_state == SW_NEW) && (tick_cnt == 2'd0);
    endsequence

    a_old_ticks: assert property (@(posedge clk_i) disable iff (!rstn_i)
        s_old_done |=> s_new_entered) else $error("switch left old clock at wrong tick");

    a_gap_gated: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (sw_state != SW_RUN) |=> !sys_clk_tick_o) else $error("tick leaked during switch");

    a_scs_reset: assert property (@(posedge clk_i)
        !rstn_i |=> (osc_ctrl.system_clock_select == 2'h0) && (sw_state == SW_RUN))
        else $error("clock select not cleared by reset");

    a_ircf_reset: assert property (@(posedge clk_i)
        !rstn_i |=> (osc_ctrl.postscaler_freq_select == 3'h6))
        else $error("postscaler not 4 MHz after reset");

    a_t1_refused: assert property (@(posedge clk_i) disable iff (!rstn_i)
        wr_ctrl && (wdata[1:0] == 2'h1) && !t1_allowed |=> $stable(osc_ctrl.system_clock_select))
        else $error("Timer1 selection not refused");

    a_mult_gate: assert property (@(posedge clk_i) disable iff (!rstn_i)
        mult_ready_o |-> osc_ctrl.system_clock_select == 2'h0
            && oscillator_config_field_i[2:1] == 2'h1)
        else $error("multiplier locked in illegal mode");

    a_mult_freq: assert property (@(posedge clk_i) disable iff (!rstn_i)
        mult_run_o |-> osc_ctrl.postscaler_freq_select[2:1] == 2'h3)
        else $error("multiplier on at illegal postscaler");

    a_lock_wait: assert property (@(posedge clk_i) disable iff (!rstn_i)
        $rose(mult_locked) |-> $past(lock_cnt) == LCW'(LOCK_CYCLES - 1))
        else $error("lock ready at wrong count");

    a_flag_excl: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !(startup_flag && timer1_clock_running_flag_o)) else $error("both source flags set");

    a_tune_write: assert property (@(posedge clk_i) disable iff (!rstn_i)
        wr_tune |=> fast_osc_trim_o == $past(hwdata_i[5:0])) else $error("trim not updated");

    a_idle_pick: assert property (@(posedge clk_i) disable iff (!rstn_i)
        sleep_exec_i |=> (enter_idle_o != enter_sleep_o)) else $error("sleep mode not chosen");

endmodule

// ---- ictl_cfg.svh ----
// Offsets, field positions, reset values and timing counts of the clock control block
`ifndef ICTL_CFG_SVH
`define ICTL_CFG_SVH

// Register indices; byte address is four times the index
`define ICTL_IDX_TUNE        12'hf9b
`define ICTL_IDX_CTRL        12'hfd3
`define ICTL_IDX_MSB         13
`define ICTL_IDX_LSB         2

// Tuning register fields and reset
`define ICTL_TUNE_LF_SRC_BIT 7
`define ICTL_TUNE_MULT_BIT   6
`define ICTL_TUNE_RESET      8'h00

// Control register fields and reset
`define ICTL_CTRL_RESET      8'h64
`define ICTL_CTRL_UNUSED_VAL 1'b1

// Field codes
`define ICTL_SCS_PRIMARY     2'h0
`define ICTL_SCS_TIMER1      2'h1
`define ICTL_SCS_RESERVED    2'h2
`define ICTL_SCS_INTERNAL    2'h3
`define ICTL_IRCF_8MHZ       3'h7
`define ICTL_IRCF_4MHZ       3'h6
`define ICTL_IRCF_31KHZ      3'h0
`define ICTL_FOSC_INTERNAL_MULTIPLIED_MODES_A   3'h3
`define ICTL_FOSC_INTERNAL_MULTIPLIED_MODES_B   3'h2
`define ICTL_FOSC_INTPS_A    3'h1
`define ICTL_FOSC_INTPS_B    3'h0

// Switch pause, counted in source ticks
`define ICTL_OLD_TICKS       2'd2
`define ICTL_NEW_TICKS       2'd3

// Multiplier lock wait
`define ICTL_CLK_MHZ         100
`define ICTL_LOCK_TIME_US    2000
`define ICTL_LOCK_CYCLES     (`ICTL_LOCK_TIME_US * `ICTL_CLK_MHZ)

`endif

// ---- ictl_pkg.sv ----
// Types shared by the clock control block
package ictl_pkg;

    // Tuning register layout
    typedef struct packed {
        logic       low_freq_source_select;
        logic       multiplier_enable;
        logic [5:0] tuning_field;
    } ictl_tune_t;

    // Control register layout
    typedef struct packed {
        logic       idle_select;
        logic [2:0] postscaler_freq_select;
        logic       startup_expired_flag;
        logic       unused;
        logic [1:0] system_clock_select;
    } ictl_ctrl_t;

    // Source clock ticks, one cycle each, from the analog oscillators
    typedef struct packed {
        logic primary;
        logic timer1;
        logic fast_osc;
        logic lf_rc;
        logic multiplied;
    } ictl_ticks_t;

    // Effective device clock sources
    typedef enum logic [1:0] {
        SRC_PRIM = 2'b00,
        SRC_T1   = 2'b01,
        SRC_INTC = 2'b10,
        SRC_MULT = 2'b11
    } ictl_src_t;

    // Glitch-free switch states
    typedef enum logic [1:0] {
        SW_RUN = 2'b00,
        SW_OLD = 2'b01,
        SW_NEW = 2'b10
    } ictl_sw_t;

endpackage

// ---- ictl_src_model.sv ----
// Tick model of the analog sources that feed the clock control block
module ictl_src_model
    import ictl_pkg::*;
#(
    parameter int P_PRIM = 4,
    parameter int P_T1   = 7,
    parameter int P_FAST = 2,
    parameter int P_LF   = 9,
    parameter int P_MULT = 3
) (
    // Clock
    input  wire logic             clk_i,
    // Source ticks
    output ictl_pkg::ictl_ticks_t ticks_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // Bit k of the tick struct uses period PER[k]; the fast oscillator stands for 8 MHz
    localparam int PER [5] = '{P_MULT, P_LF, P_FAST, P_T1, P_PRIM};
    int            cnt [5] = '{default: 0};

    // Sources run free from time zero, so Timer1 is stable before any selection
    always @(posedge clk_i) begin
        for (int k = 0; k < 5; k++) begin
            cnt[k] <= (cnt[k] == PER[k] - 1) ? 0 : cnt[k] + 1;
        end
    end

    // One-cycle tick at the end of each period
    always_comb begin
        for (int k = 0; k < 5; k++) begin
            ticks_o[k] = (cnt[k] == PER[k] - 1);
        end
    end
endmodule

// ---- tb_internal_osc_tune_pll_clock_select.sv ----
// Self-checking bench for the clock control block
`include "ictl_cfg.svh"
module tb_internal_osc_tune_pll_clock_select;
    timeunit 1ns;
    timeprecision 1ps;
    import ictl_pkg::*;

    typedef struct packed {
        logic [11:0] idx;
        logic [7:0]  wd;
        logic [7:0]  rd;
        logic [5:0]  trim;
    } ictl_row_t;

    localparam int LOCK = 20;
    localparam logic [11:0] TUNE = `ICTL_IDX_TUNE;
    localparam logic [11:0] CTRL = `ICTL_IDX_CTRL;
    // Tuning codes stepped up and down, and an unmapped index that must change nothing
    localparam ictl_row_t ROWS [6] = '{
        '{TUNE, 8'h1f, 8'h1f, 6'h1f},
        '{TUNE, 8'h00, 8'h00, 6'h00},
        '{TUNE, 8'h20, 8'h20, 6'h20},
        '{TUNE, 8'h3f, 8'h3f, 6'h3f},
        '{12'h123, 8'haa, 8'h00, 6'h3f},
        '{TUNE, 8'h00, 8'h00, 6'h00}};

    logic        clk_i = 1'b0;
    logic        rstn_i = 1'b0;
    logic        hsel = 1'b0, hwrite = 1'b0, t1_xtal = 1'b0, ost_done = 1'b0, sleep_ex = 1'b0;
    logic        t1_dig = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [2:0]  cfg = 3'h4;
    logic        hready, hresp, sys_tick, wdt_tick, mrun, mready, sw, timer1_clock_running_flag, e_idle, e_sleep;
    logic [5:0]  trim;
    ictl_ticks_t ticks;
    int          n_mismatch = 0;
    int          n_compared = 0;

    initial forever #5 clk_i = ~clk_i;

    ictl_src_model i_src (.clk_i(clk_i), .ticks_o(ticks));

    ictl_top #(.LOCK_CYCLES(LOCK)) i_dut (
        .clk_i(clk_i), .rstn_i(rstn_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
        .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp), .ticks_i(ticks),
        .oscillator_config_field_i(cfg), .timer1_crystal_driver_enable_i(t1_xtal),
        .timer1_digital_input_config_i(t1_dig), .ost_done_i(ost_done), .sleep_exec_i(sleep_ex),
        .sys_clk_tick_o(sys_tick), .wdt_clk_tick_o(wdt_tick), .fast_osc_trim_o(trim),
        .mult_run_o(mrun), .mult_ready_o(mready), .switching_o(sw),
        .timer1_clock_running_flag_o(timer1_clock_running_flag), .enter_idle_o(e_idle), .enter_sleep_o(e_sleep));

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic in_range(input int n, input int lo, input int hi);
        check({31'h0, n >= lo && n <= hi}, 32'h1);
    endtask

    // A wait that runs out of its bound counts as a mismatch and ends the run
    task automatic give_up(input bit hit);
        if (hit) begin
            n_mismatch++;
            conclude();
        end
    endtask

    // Edge at which hready is sampled high; a stuck slave ends the run
    task automatic hwait();
        int n;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (hready !== 1'b1 && n < 50);
        if (n >= 50) begin
            n_mismatch++;
            conclude();
        end
    endtask

    // One single-word transfer; byte address is four times the index
    task automatic bus(input logic wr, input logic [11:0] idx, input logic [7:0] wd,
                       output logic [7:0] rd);
        @(posedge clk_i);
        haddr  <= {18'h0, idx, 2'b00};
        htrans <= 2'b10;
        hwrite <= wr;
        hsel   <= 1'b1;
        hwait();
        htrans <= 2'b00;
        hsel   <= 1'b0;
        hwdata <= {24'h0, wd};
        hwait();
        check(hresp, 1'b0);
        rd = hrdata[7:0];
    endtask

    // Device ticks over a window; the watchdog tick must mirror the RC all along
    task automatic count_ticks(input int cyc, output int n);
        n = 0;
        repeat (cyc) begin
            @(negedge clk_i);
            n += int'(sys_tick);
            check(wdt_tick, ticks.lf_rc);
        end
    endtask

    // Pause length is bounded by the tick periods of the old and new sources
    task automatic wait_sw(input int po, input int pn);
        int n;
        n = 0;
        while (sw !== 1'b1 && n < 20) begin
            @(negedge clk_i);
            n++;
        end
        give_up(sw !== 1'b1);
        n = 0;
        while (sw === 1'b1 && n < 3000) begin
            @(negedge clk_i);
            n++;
            check(sys_tick, 1'b0);
        end
        give_up(n >= 3000);
        in_range(n, po + 2 * pn - 1, 2 * po + 3 * pn + 4);
    endtask

    initial begin
        logic [7:0] r;
        int         n;
        repeat (8) @(posedge clk_i);
        rstn_i <= 1'b1;
        bus(0, TUNE, 8'h00, r);
        check(r, 8'h00);
        bus(0, CTRL, 8'h00, r);
        check(r, 8'h64);
        foreach (ROWS[i]) begin
            bus(1, ROWS[i].idx, ROWS[i].wd, r);
            @(negedge clk_i);
            check(trim, ROWS[i].trim);
            bus(0, ROWS[i].idx, 8'h00, r);
            check(r, ROWS[i].rd);
        end
        // Sleep instruction with idle select set, then clear
        for (int k = 0; k < 2; k++) begin
            bus(1, CTRL, k ? 8'h64 : 8'he4, r);
            @(posedge clk_i);
            sleep_ex <= 1'b1;
            @(posedge clk_i);
            sleep_ex <= 1'b0;
            @(negedge clk_i);
            check({e_idle, e_sleep}, k ? 2'b01 : 2'b10);
        end
        // Timer1 select refused while both enables are off, then taken on the digital input
        bus(1, CTRL, 8'h65, r);
        bus(0, CTRL, 8'h00, r);
        check(r, 8'h64);
        t1_dig <= 1'b1;
        bus(1, CTRL, 8'h65, r);
        wait_sw(4, 7);
        check(timer1_clock_running_flag, 1'b1);
        bus(1, CTRL, 8'h67, r);
        wait_sw(7, 4);
        check(timer1_clock_running_flag, 1'b0);
        // Postscaler codes 111 down to 001, each step halving the rate
        for (int p = 7; p >= 1; p--) begin
            bus(1, CTRL, {1'b0, 3'(p), 4'h3}, r);
            count_ticks(130, n);
            count_ticks(256, n);
            in_range(n, (128 >> (7 - p)) - 1, (128 >> (7 - p)) + 1);
        end
        bus(1, CTRL, 8'h12, r);
        bus(0, CTRL, 8'h00, r);
        check(r, 8'h17);
        // 31 kHz code: RC direct, then fast oscillator divided by 256
        bus(1, CTRL, 8'h03, r);
        count_ticks(20, n);
        count_ticks(90, n);
        in_range(n, 9, 11);
        bus(1, TUNE, 8'h80, r);
        count_ticks(600, n);
        in_range(n, 1, 2);
        // Multiplier: back to primary in a multiplier mode, then enable and wait for lock
        bus(1, TUNE, 8'h00, r);
        cfg <= 3'h3;
        bus(1, CTRL, 8'h64, r);
        wait_sw(4, 4);
        check(mrun, 1'b0);
        ost_done <= 1'b1;
        bus(1, TUNE, 8'h40, r);
        @(negedge clk_i);
        check(mrun, 1'b1);
        n = 0;
        while (mready !== 1'b1 && n < 100) begin
            @(negedge clk_i);
            n++;
            check(sw, 1'b0);
        end
        give_up(n >= 100);
        in_range(n, LOCK - 1, LOCK + 1);
        wait_sw(4, 3);
        count_ticks(60, n);
        in_range(n, 19, 21);
        bus(0, CTRL, 8'h00, r);
        check(r, 8'h6c);
        bus(1, CTRL, 8'h54, r);
        @(negedge clk_i);
        check({mrun, mready}, 2'b00);
        bus(1, CTRL, 8'h64, r);
        cfg <= 3'h1;
        @(negedge clk_i);
        check(mrun, 1'b0);
        // Reset in mid-run restores select and postscaler
        @(posedge clk_i);
        rstn_i   <= 1'b0;
        ost_done <= 1'b0;
        repeat (3) @(posedge clk_i);
        rstn_i <= 1'b1;
        bus(0, CTRL, 8'h00, r);
        check(r, 8'h64);
        bus(0, TUNE, 8'h00, r);
        check(r, 8'h00);
        // Timer1 select taken on the crystal driver enable alone
        t1_dig  <= 1'b0;
        t1_xtal <= 1'b1;
        bus(1, CTRL, 8'h65, r);
        bus(0, CTRL, 8'h00, r);
        check(r, 8'h65);
        conclude();
    end
endmodule
